/* design/fiber_sd_polarity_strap_status.sv */
// Purpose: Fiber signal-detect polarity control and strap latch status over APB
// Assumes: Single clock mclk at 100 MHz, synchronous active-high reset
// Notes:   Registers sit at byte address four times their index
// Notes on behaviour
// - Config bit 0 clear means signal detect is active high, set means active low, reset clear.
// - With active-high polarity the link drops while signal detect is sampled low.
// - With active-low polarity the link drops while signal detect is sampled high.
// - Signal detection on indicator pin one works only if the enable strap latched one.
// - Bits 15:14 report the receive-data-bit-1 strap mode, codes 00..11 for modes 1..4, reset 00.
// - Bits 13:12, 11:10 and 9:8 report receive-data-bit-0, collision and receive-error strap modes.
// - Bits 7:6 report carrier-sense and bits 5:4 receive-data-valid strap modes.
// - Collision, receive-error and carrier-sense fields default 11, the receive-data and receive-data-valid fields 00.
// - Bits 1:0 report indicator pin zero strap mode, 00 or 11 only, default 11.
// - Reported codes name the mode only, not the pin bit pattern.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module fiber_sd_polarity_strap_status
  import fiber_strap_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Strap mode codes from pin sense
  input  wire strap_modes_t strapModes,
  // Fiber link
  input  wire logic        indicatorPinOne,
  input  wire logic        fiberLinkUp,
  output logic             fiberLinkDrop,
  output logic             fiberLinkOk
);

  logic [15:0]  fiberConfig;
  logic [15:0]  strapStatus;
  logic [14:0]  strapLatched;
  logic         strapDone;
  strap_modes_t modesLatched;
  logic         sdMeta;
  logic         sdSync;
  logic         signalPresent;
  logic         polarityLow;
  logic         sdEnabled;
  logic         addrCfg;
  logic         addrStrap;
  logic         accessPhase;

  strap_capture #(
    .WIDTH (15)
  ) u_capture (
    .mclk         (mclk),
    .reset        (reset),
    .strapPins    (strapModes),
    .strapLatched (strapLatched),
    .strapDone    (strapDone)
  );

  assign modesLatched = strapLatched;

  // Codes are mode numbers, passed through unchanged except reserved LED0 codes
  always_comb
  begin
    strapStatus                       = 16'h0000;
    strapStatus[RXD1_POS+1:RXD1_POS]  = modesLatched.rxd1;
    strapStatus[RXD0_POS+1:RXD0_POS]  = modesLatched.rxd0;
    strapStatus[COL_POS+1:COL_POS]    = modesLatched.col;
    strapStatus[RXER_POS+1:RXER_POS]  = modesLatched.rxEr;
    strapStatus[CRS_POS+1:CRS_POS]    = modesLatched.crs;
    strapStatus[RXDV_POS+1:RXDV_POS]  = modesLatched.rxDv;
    // Reserved LED0 codes fold to mode 1
    strapStatus[LED0_POS+1:LED0_POS]  = (modesLatched.led0 == MODE_4) ? MODE_4 : MODE_1;
  end

  assign polarityLow = fiberConfig[POLARITY_BIT];
  assign sdEnabled   = modesLatched.sdEnable & strapDone;

  // Pin is asynchronous to mclk
  always_ff @(posedge mclk)
  begin
    sdMeta <= indicatorPinOne;
    sdSync <= sdMeta;
  end

  assign signalPresent = polarityLow ? !sdSync : sdSync;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      fiberLinkDrop <= 1'b0;
      fiberLinkOk   <= 1'b0;
    end
    else
    begin
      // Without the strap the pin is not a detect input, drop never forced
      fiberLinkDrop <= sdEnabled && !signalPresent;
      fiberLinkOk   <= fiberLinkUp && !(sdEnabled && !signalPresent);
    end
  end

  // APB decode, zero wait states
  assign addrCfg     = paddr == {18'h0, FIBER_CFG_ADDR};
  assign addrStrap   = paddr == {18'h0, STRAP_STATUS_ADDR};
  assign accessPhase = psel && penable;
  assign pready      = 1'b1;
  assign pslverr     = accessPhase && !addrCfg && !addrStrap;

  always_ff @(posedge mclk)
  begin
    if (reset)
      fiberConfig <= FIBER_CFG_RESET;
    else if (accessPhase && pwrite && addrCfg)
      fiberConfig <= pwdata[15:0] & FIBER_CFG_RW_MASK;
  end

  // Read data registered in setup phase so it is stable in access phase
  always_ff @(posedge mclk)
  begin
    if (reset)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      if (addrCfg)
        prdata <= {16'h0000, fiberConfig};
      else if (addrStrap)
        prdata <= {16'h0000, strapStatus};
      else
        prdata <= 32'h0000_0000;
    end
  end

  property p_drop_high;
    @(posedge mclk) disable iff (reset)
      (sdEnabled && !polarityLow && !sdSync) |=> fiberLinkDrop;
  endproperty
  a_drop_high: assert property (p_drop_high) else $error("no drop on low detect");

  property p_drop_low;
    @(posedge mclk) disable iff (reset)
      (sdEnabled && polarityLow && sdSync) |=> fiberLinkDrop;
  endproperty
  a_drop_low: assert property (p_drop_low) else $error("no drop on high detect");

  property p_no_drop_unstrapped;
    @(posedge mclk) disable iff (reset)
      !sdEnabled |=> !fiberLinkDrop;
  endproperty
  a_no_drop_unstrapped: assert property (p_no_drop_unstrapped) else $error("drop without strap");

  property p_polarity_reset;
    @(posedge mclk) $fell(reset) |-> !polarityLow;
  endproperty
  a_polarity_reset: assert property (p_polarity_reset) else $error("polarity not cleared");

  property p_strap_hold;
    @(posedge mclk) disable iff (reset)
      strapDone |=> $stable(strapStatus);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap status changed");

  // Field must carry the pin code seen two edges before the strapDone rise is sampled, one edge before capture
  property p_rxd1_field;
    @(posedge mclk) disable iff (reset)
      $rose(strapDone) |-> strapStatus[15:14] == $past(strapModes.rxd1, 2);
  endproperty
  a_rxd1_field: assert property (p_rxd1_field) else $error("rxd1 field wrong");

  property p_defaults;
    @(posedge mclk) $fell(reset) |-> strapStatus == STRAP_STATUS_RESET;
  endproperty
  a_defaults: assert property (p_defaults) else $error("strap defaults wrong");

  property p_led0_legal;
    @(posedge mclk) disable iff (reset)
      strapStatus[1:0] == MODE_1 || strapStatus[1:0] == MODE_4;
  endproperty
  a_led0_legal: assert property (p_led0_legal) else $error("led0 reserved code");

  property p_fields;
    @(posedge mclk) disable iff (reset)
      strapStatus[13:4] == {modesLatched.rxd0, modesLatched.col, modesLatched.rxEr,
                            modesLatched.crs, modesLatched.rxDv};
  endproperty
  a_fields: assert property (p_fields) else $error("strap field placement wrong");

  property p_capture_time;
    @(posedge mclk) $fell(reset) |-> ##[0:8] strapDone;
  endproperty
  a_capture_time: assert property (p_capture_time) else $error("strap not captured");

endmodule // fiber_sd_polarity_strap_status
`default_nettype wire

/* design/strap_capture.sv */
// Purpose: Synchronise strap pins and latch them once after reset release
// Assumes: Strap pins are static around reset release
// Notes:   Capture happens after a short settle so the synchronisers are full
`timescale 1ns/1ps
`default_nettype none
module strap_capture
  import fiber_strap_pkg::*;
#(
  parameter int WIDTH = 15
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // Raw strap levels
  input  wire logic [WIDTH-1:0] strapPins,
  // Latched result
  output logic      [WIDTH-1:0] strapLatched,
  output logic                  strapDone
);

  logic [WIDTH-1:0] syncFirst;
  logic [WIDTH-1:0] syncSecond;
  logic [2:0]       settleCount;

  always_ff @(posedge mclk)
  begin
    syncFirst  <= strapPins;
    syncSecond <= syncFirst;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      settleCount <= 3'h0;
    else if (!strapDone)
      settleCount <= settleCount + 3'h1;
  end

  // One capture per reset, then frozen
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      strapLatched <= STRAP_LATCH_RESET[WIDTH-1:0];
      strapDone    <= 1'b0;
    end
    else if (!strapDone && settleCount == 3'(STRAP_SETTLE_CYCLES))
    begin
      strapLatched <= syncSecond;
      strapDone    <= 1'b1;
    end
  end

endmodule // strap_capture
`default_nettype wire

/* shared/fiber_strap_pkg.sv */
// Purpose: Shared constants and carriers for the fiber polarity / strap status bank
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Printed offsets are not multiples of four, so they are register indices
package fiber_strap_pkg;

  // Register indices and byte addresses
  localparam logic [11:0] FIBER_CFG_INDEX    = 12'h0465;
  localparam logic [11:0] STRAP_STATUS_INDEX = 12'h0467;
  localparam logic [13:0] FIBER_CFG_ADDR     = {FIBER_CFG_INDEX, 2'b00};
  localparam logic [13:0] STRAP_STATUS_ADDR  = {STRAP_STATUS_INDEX, 2'b00};

  // Fiber configuration layout
  localparam int          POLARITY_BIT       = 0;
  localparam logic [15:0] FIBER_CFG_RESET    = 16'hFF00;
  localparam logic [15:0] FIBER_CFG_RW_MASK  = 16'hFFFF;

  // Strap status field positions (low bit)
  localparam int RXD1_POS  = 14;
  localparam int RXD0_POS  = 12;
  localparam int COL_POS   = 10;
  localparam int RXER_POS  = 8;
  localparam int CRS_POS   = 6;
  localparam int RXDV_POS  = 4;
  localparam int LED0_POS  = 0;

  // Strap field defaults
  localparam logic [1:0] MODE_1 = 2'h0;
  localparam logic [1:0] MODE_4 = 2'h3;
  localparam logic [15:0] STRAP_STATUS_RESET = 16'h0FC3;
  // Same defaults in strap_modes_t order, strap enable cleared
  localparam logic [14:0] STRAP_LATCH_RESET  = 15'h07E6;

  // Strap sample window after reset release
  localparam int STRAP_SETTLE_CYCLES = 4;

  // Mode codes of each strap pin, as sampled from the pin sense circuit
  typedef struct packed {
    logic [1:0] rxd1;
    logic [1:0] rxd0;
    logic [1:0] col;
    logic [1:0] rxEr;
    logic [1:0] crs;
    logic [1:0] rxDv;
    logic [1:0] led0;
    logic       sdEnable;
  } strap_modes_t;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

/* testbench/fiber_sd_polarity_strap_status_tb_top.sv */
// Purpose: Self-checking bench for the fiber polarity and strap status bank
// Assumes: Zero-wait APB slave, straps latched five edges after reset release
// Notes:   Expected values are rebuilt here from the field layout
`timescale 1ns/1ps
`default_nettype none
module fiber_sd_polarity_strap_status_tb_top;
  import fiber_strap_pkg::*;
  logic         mclk, reset, psel, penable, pwrite, light, activeLow, fiberLinkUp;
  logic         pready, pslverr, err, sdPin, fiberLinkDrop, fiberLinkOk, expDrop;
  logic [31:0]  paddr, pwdata, prdata, rd, expStat, cfg;
  strap_modes_t strapModes, s;
  logic [7:0]   rnd = 8'h59;
  int           miscompares = 0;
  int           nTests = 0;

  fiber_sd_polarity_strap_status fiber_sd_polarity_strap_status_i (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strapModes(strapModes), .indicatorPinOne(sdPin), .fiberLinkUp(fiberLinkUp),
    .fiberLinkDrop(fiberLinkDrop), .fiberLinkOk(fiberLinkOk));
  sd_transceiver_model sd_transceiver_model_i (.mclk(mclk), .lightPresent(light), .activeLow(activeLow),
    .sigDetect(sdPin));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    nTests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One edge first, so back-to-back calls never drive psel twice in a step
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      miscompares++;
      wrapUp();
    end
  endtask

  task automatic doReset(input int cycles);
    reset <= 1'b1;
    repeat (cycles) @(posedge mclk);
    reset <= 1'b0;
  endtask

  initial
  begin
    {psel, penable, pwrite, light, activeLow, fiberLinkUp} = '0;
    paddr = '0;
    pwdata = '0;
    reset = 1'b1;
    strapModes = '0;
    for (int it = 0; it < 2; it++)
    begin
      rnd = lfsr(rnd);
      s[14:8] = rnd[6:0];
      rnd = lfsr(rnd);
      s[7:0] = rnd;
      // Second pass drives a reserved code, which must fold to mode 1
      s.led0 = it[0] ? 2'b10 : {2{s.led0[0]}};
      s.sdEnable = it[0];
      strapModes <= s;
      doReset(it == 0 ? 12 : 2);
      apb(1'b0, 32'(STRAP_STATUS_ADDR), '0);
      check(rd, 32'(STRAP_STATUS_RESET), "strap defaults");
      apb(1'b0, 32'(FIBER_CFG_ADDR), '0);
      check(rd, 32'(FIBER_CFG_RESET), "config reset");
      repeat (8) @(posedge mclk);
      expStat = {16'h0000, s.rxd1, s.rxd0, s.col, s.rxEr, s.crs, s.rxDv, 2'b00,
                 (s.led0 == MODE_4) ? MODE_4 : MODE_1};
      apb(1'b0, 32'(STRAP_STATUS_ADDR), '0);
      check(rd, expStat, "strap fields");
      // Pins move and software tries a write: both must leave the latch alone
      strapModes <= ~s;
      apb(1'b1, 32'(STRAP_STATUS_ADDR), 32'hFFFF_FFFF);
      apb(1'b0, 32'(STRAP_STATUS_ADDR), '0);
      check(rd, expStat, "strap held");
      apb(1'b1, 32'h0000_0010, 32'h0000_FFFF);
      check(32'(err), 32'h0000_0001, "unmapped error");
      for (int k = 0; k < 8; k++)
      begin
        cfg = 32'h0000_FF00 + 32'(k % 2);
        apb(1'b1, 32'(FIBER_CFG_ADDR), cfg);
        rnd = lfsr(rnd);
        light <= k[1];
        activeLow <= k[2];
        fiberLinkUp <= rnd[0];
        apb(1'b0, 32'(FIBER_CFG_ADDR), '0);
        check(rd, cfg, "config readback");
        repeat (6) @(posedge mclk);
        expDrop = it[0] & ((k[1] ^ k[2]) == k[0]);
        check(32'(fiberLinkDrop), 32'(expDrop), "link drop");
        check(32'(fiberLinkOk), 32'(rnd[0] & ~expDrop), "link ok");
      end
    end
    wrapUp();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    wrapUp();
  end
endmodule // fiber_sd_polarity_strap_status_tb_top
`default_nettype wire

/* testbench/sd_transceiver_model.sv */
// Purpose: Far-end fiber transceiver signal-detect output
// Assumes: Light level and output sense come from the bench
// Notes:   Registered, so the pin only moves after a clock edge
`timescale 1ns/1ps
`default_nettype none
module sd_transceiver_model
(
  // Clock
  input  wire logic mclk,
  // Optical state
  input  wire logic lightPresent,
  input  wire logic activeLow,
  // Signal-detect pin
  output logic      sigDetect
);
  // Inverted sense mimics a module built for the other polarity
  always_ff @(posedge mclk)
  begin
    sigDetect <= lightPresent ^ activeLow;
  end
endmodule // sd_transceiver_model
`default_nettype wire
